// *** rtl/ise_pkg.sv ***
package ise_pkg;

    // Core clock.
    localparam int CLK_PERIOD_NS = 4;

    // Pulses on the bus inputs up to this width are suppressed.
    localparam int GLITCH_FILTER_WIDTH_NS = 100;
    localparam int GLITCH_CYC_RAW = GLITCH_FILTER_WIDTH_NS / CLK_PERIOD_NS;
    localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;

    // Longest self-timed programming cycle.
    localparam int WRITE_CYCLE_TIME_NS = 5000000;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;

    // Delay from supply stable to the first accepted command.
    localparam int POWERUP_READY_TIME_NS = 1000000;
    localparam int POWERUP_CYC = POWERUP_READY_TIME_NS / CLK_PERIOD_NS;

    // Array organisation.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_OFS_W = 4;
    localparam int MEM_BYTES_SMALL = 256;
    localparam int MEM_BYTES_LARGE = 512;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

    // Bit counter marks inside one byte slot, and the last offset inside one page.
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [PAGE_OFS_W-1:0] OFS_LAST = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WADDR,
        ST_WDATA,
        ST_RDATA
    } ise_state_t;

    typedef enum logic [1:0] {
        CM_IDLE,
        CM_PROG,
        CM_WAIT
    } ise_commit_t;

    typedef struct packed {
        logic [PAGE_OFS_W-1:0] offset;
        logic [DATA_W-1:0] data;
    } ise_wr_entry_t;

endpackage

// *** rtl/ise_fifo.sv ***
`timescale 1ns/1ns
module ise_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic clk_i, // Core clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic in_valid_i, // Write side offers a word.
    input wire logic [W-1:0] in_data_i, // Word offered.
    output logic in_ready_o, // Buffer has room.
    output logic out_valid_o, // Buffer holds a word.
    output logic [W-1:0] out_data_o, // Oldest word.
    input wire logic out_ready_i // Read side takes the word.
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("ise_fifo depth must be a power of two of at least two");
    end

    logic [W-1:0] buf_q [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    assign in_ready_o = (cnt_q != (PW + 1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = buf_q[rp_q];
    assign do_push = in_valid_i && in_ready_o;
    assign do_pop = out_valid_o && out_ready_i;

    always_comb begin
        wp_d = wp_q + PW'(do_push);
        rp_d = rp_q + PW'(do_pop);
        cnt_d = cnt_q + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            buf_q[wp_q] <= in_data_i;
        end
    end
endmodule

// *** rtl/ise_mem.sv ***
`timescale 1ns/1ns
module ise_mem #(
    parameter int W = 8,
    parameter int DEPTH = 512,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk_i, // Core clock.
    input wire logic we_i, // Write strobe.
    input wire logic [$clog2(DEPTH)-1:0] waddr_i, // Write address.
    input wire logic [W-1:0] wdata_i, // Write data.
    input wire logic [$clog2(DEPTH)-1:0] raddr_i, // Read address.
    output logic [W-1:0] rdata_o // Registered read data.
);
    // The array leaves the factory erased.
    logic [W-1:0] mem_q [DEPTH] = '{default: INIT};
    logic [W-1:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_q <= mem_q[raddr_i];
    end

    assign rdata_o = rdata_q;
endmodule

// *** rtl/ise_eeprom.sv ***
`timescale 1ns/1ns
// Functional notes
// [RULE_01] Array is 16-byte pages, 256 or 512 bytes.
// [RULE_02] One to sixteen bytes buffered, committed once.
// [RULE_03] Reads stream bytes, pointer advances per byte.
// [RULE_04] Protect input high blocks upper-half writes.
// [RULE_05] Chip-select pins form part of bus address.
// [RULE_06] Works with 100 kHz and 400 kHz clocks.
// [RULE_07] Bus input pulses up to 100 ns ignored.
// [RULE_08] Ready for commands within 1 ms.
// [RULE_09] Power-on reset forces standby, brown-out recovery.
// [RULE_10] Undriven protect input counts as low; no pull-down here, wp_i is used as sampled.
// [RULE_11] Programming cycle bounded by 5 ms timer.
// [RULE_12] Type code and selects must match; bit0 direction.
// [RULE_13] Page write wraps low four address bits.
// [RULE_14] Protect sampled before first data byte; NACK.
// [RULE_15] Busy device releases data, acknowledges nothing.
module ise_eeprom
    import ise_pkg::*;
#(
    parameter int MEM_BYTES = ise_pkg::MEM_BYTES_LARGE,
    parameter int WR_CYC = ise_pkg::WRITE_CYCLE_CYC,
    parameter int PU_CYC = ise_pkg::POWERUP_CYC,
    parameter logic [3:0] TYPE_CODE = 4'h6, // Arbitrary value.
    parameter int FIFO_DEPTH = 2
) (
    input wire logic mclk_i, // Core clock, 250 MHz.
    input wire logic rst_n_i, // Power-on reset, active low.
    input wire logic scl_i, // Serial clock pin.
    input wire logic sda_i, // Serial data pin level.
    output logic sda_o, // Serial data drive value, always low.
    output logic sda_oe_n_o, // Low while pulling data low.
    input wire logic [2:0] chip_select_pins_i, // Address select pins.
    input wire logic wp_i, // Write protect pin.
    output logic ready_o // Device accepts commands.
);
    import ise_pkg::*;

    localparam logic [ADDR_W-1:0] AMASK = ADDR_W'(MEM_BYTES - 1);
    localparam logic [31:0] WAIT_LAST = 32'(WR_CYC - PAGE_BYTES - 1);
    localparam logic [31:0] PU_LAST = 32'(PU_CYC - 1);

    if (!(MEM_BYTES == MEM_BYTES_SMALL || MEM_BYTES == MEM_BYTES_LARGE) || WR_CYC <= PAGE_BYTES + 1
        || PU_CYC < 1 || FIFO_DEPTH != 2) begin : g_chk
        $error("ise_eeprom parameters out of range");
    end

    // Two flip-flop synchronisers: scl, sda, wp, chip selects.
    logic [5:0] raw_in, sync1_q, sync2_q;
    assign raw_in = {chip_select_pins_i, wp_i, sda_i, scl_i};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 6'h03;
            sync2_q <= 6'h03;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // A protect pin left open is not pulled low here: wp_s follows the synchronised wp_i, which reset loads low.
    logic wp_s; // [RULE_10]
    logic [2:0] cs_s;
    assign wp_s = sync2_q[2];
    assign cs_s = sync2_q[5:3];

    // A level change is accepted only once it has held longer than the glitch width.
    // The added delay stays far below the shortest fast-mode low time. [RULE_06]
    logic [1:0] filt_q, filt_d, prev_q;
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic [7:0] fc_q, fc_d;
        always_comb begin
            fc_d = '0;
            filt_d[g] = filt_q[g];
            if (sync2_q[g] != filt_q[g]) begin
                fc_d = fc_q + 8'h01;
                if (fc_q == 8'(GLITCH_CYC)) begin // [RULE_07]
                    filt_d[g] = sync2_q[g];
                    fc_d = '0;
                end
            end
        end
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                fc_q <= '0;
                filt_q[g] <= 1'b1;
                prev_q[g] <= 1'b1;
            end else begin
                fc_q <= fc_d;
                filt_q[g] <= filt_d[g];
                prev_q[g] <= filt_q[g];
            end
        end
    end

    logic scl_f, sda_f, rise, fall, start_ev, stop_ev;
    assign scl_f = filt_q[0];
    assign sda_f = filt_q[1];
    assign rise = scl_f && !prev_q[0];
    assign fall = !scl_f && prev_q[0];
    assign start_ev = scl_f && prev_q[0] && prev_q[1] && !sda_f;
    assign stop_ev = scl_f && prev_q[0] && !prev_q[1] && sda_f;

    // Shared state between the bus engine and the commit path.
    ise_state_t st_q, st_d;
    ise_commit_t cm_q, cm_d;
    logic [3:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] sh_q, sh_d, mem_rdata;
    logic drv_q, drv_d, rw_q, rw_d, hi_q, hi_d, mack_q, mack_d, prot_q, prot_d;
    logic [ADDR_W-1:0] addr_q, addr_d, word_addr;
    logic push, new_page, abort, pend_set, ready, dev_match, upper_half;
    logic pend_q, pend_d, pu_done_q, pu_done_d, ready_q;
    logic [31:0] pu_cnt_q, pu_cnt_d, tmr_q, tmr_d;
    logic [PAGE_OFS_W-1:0] ci_q, ci_d;
    logic [DATA_W-1:0] pb_q [PAGE_BYTES];
    logic [DATA_W-1:0] pb_d [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q, mask_d;
    logic [ADDR_W-PAGE_OFS_W-1:0] page_q, page_d;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    ise_wr_entry_t fifo_in, fifo_out;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;

    assign ready = pu_done_q && (cm_q == CM_IDLE) && !pend_q; // [RULE_15]
    assign word_addr = {hi_q, sh_q} & AMASK;
    assign upper_half = (MEM_BYTES == MEM_BYTES_LARGE) ? addr_q[8] : addr_q[7];
    assign fifo_in = '{offset: addr_q[PAGE_OFS_W-1:0], data: sh_q};

    always_comb begin
        if (MEM_BYTES == MEM_BYTES_LARGE) begin
            dev_match = (sh_q[7:4] == TYPE_CODE) && (sh_q[3:2] == cs_s[2:1]); // [RULE_05] [RULE_12]
        end else begin
            dev_match = (sh_q[7:4] == TYPE_CODE) && (sh_q[3:1] == cs_s); // [RULE_05] [RULE_12]
        end
    end

    // Bus engine: bits are taken on rising clock edges and driven after falling ones.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        drv_d = drv_q;
        rw_d = rw_q;
        hi_d = hi_q;
        addr_d = addr_q;
        mack_d = mack_q;
        prot_d = prot_q;
        push = 1'b0;
        new_page = 1'b0;
        abort = 1'b0;
        pend_set = 1'b0;
        if (start_ev) begin
            abort = (st_q == ST_WDATA);
            st_d = ST_DEV;
            cnt_d = '0;
            drv_d = 1'b0;
        end else if (stop_ev) begin
            pend_set = (st_q == ST_WDATA) && (fifo_out_valid || mask_q != '0); // [RULE_02]
            st_d = ST_IDLE;
            drv_d = 1'b0;
        end else if (st_q != ST_IDLE) begin
            if (rise) begin
                if (cnt_q < BIT_LAST) begin
                    cnt_d = cnt_q + 4'h1;
                    if (st_q != ST_RDATA) begin
                        sh_d = {sh_q[6:0], sda_f};
                    end
                end else if (cnt_q == BIT_LAST) begin
                    cnt_d = BIT_ACK;
                    mack_d = !sda_f;
                end
            end else if (fall) begin
                if (cnt_q == BIT_LAST) begin
                    unique case (st_q)
                        ST_DEV: begin
                            if (dev_match && ready) begin // [RULE_15]
                                drv_d = 1'b1;
                                rw_d = sh_q[0]; // [RULE_12]
                                hi_d = sh_q[1];
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end
                        ST_WADDR: begin
                            drv_d = 1'b1;
                            addr_d = word_addr;
                            new_page = 1'b1;
                        end
                        ST_WDATA: begin
                            if (!prot_q && fifo_in_ready) begin // [RULE_04] [RULE_14]
                                drv_d = 1'b1;
                                push = 1'b1;
                                addr_d[PAGE_OFS_W-1:0] = addr_q[PAGE_OFS_W-1:0] + 4'h1; // [RULE_13]
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end
                        ST_RDATA: drv_d = 1'b0;
                        ST_IDLE: ;
                    endcase
                end else if (cnt_q == BIT_ACK) begin
                    cnt_d = '0;
                    drv_d = 1'b0;
                    unique case (st_q)
                        ST_DEV: begin
                            if (rw_q) begin
                                st_d = ST_RDATA;
                                sh_d = mem_rdata;
                                drv_d = !mem_rdata[7];
                                addr_d = (addr_q + 9'h001) & AMASK; // [RULE_03]
                            end else begin
                                st_d = ST_WADDR;
                            end
                        end
                        ST_WADDR: begin
                            st_d = ST_WDATA;
                            prot_d = wp_s && upper_half; // [RULE_14]
                        end
                        ST_RDATA: begin
                            if (mack_q) begin
                                sh_d = mem_rdata;
                                drv_d = !mem_rdata[7];
                                addr_d = (addr_q + 9'h001) & AMASK; // [RULE_03]
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end
                        ST_WDATA: ;
                        ST_IDLE: ;
                    endcase
                end else if (st_q == ST_RDATA) begin
                    sh_d = {sh_q[6:0], 1'b1};
                    drv_d = !sh_q[6];
                end
            end
        end
    end

    // Page buffer and self-timed commit of the buffered bytes.
    assign fifo_out_ready = (cm_q == CM_IDLE);

    always_comb begin
        pb_d = pb_q;
        mask_d = mask_q;
        page_d = page_q;
        cm_d = cm_q;
        ci_d = ci_q;
        tmr_d = tmr_q;
        pend_d = pend_q || pend_set;
        mem_we = 1'b0;
        mem_waddr = {page_q, ci_q};
        if (new_page || abort) begin
            mask_d = '0;
            page_d = word_addr[ADDR_W-1:PAGE_OFS_W];
        end
        if (fifo_out_valid && fifo_out_ready) begin
            pb_d[fifo_out.offset] = fifo_out.data; // [RULE_13]
            mask_d[fifo_out.offset] = 1'b1;
        end
        unique case (cm_q)
            CM_IDLE: begin
                if (pend_q && !fifo_out_valid) begin
                    pend_d = pend_set;
                    cm_d = CM_PROG;
                    ci_d = '0;
                end
            end
            CM_PROG: begin
                mem_we = mask_q[ci_q]; // [RULE_02]
                ci_d = ci_q + 4'h1;
                if (ci_q == OFS_LAST) begin
                    mask_d = '0;
                    tmr_d = '0;
                    cm_d = CM_WAIT;
                end
            end
            CM_WAIT: begin
                tmr_d = tmr_q + 32'h1;
                if (tmr_q == WAIT_LAST) begin // [RULE_11]
                    cm_d = CM_IDLE;
                end
            end
        endcase
        pu_cnt_d = pu_cnt_q;
        pu_done_d = pu_done_q;
        if (!pu_done_q) begin
            pu_cnt_d = pu_cnt_q + 32'h1;
            pu_done_d = (pu_cnt_q == PU_LAST); // [RULE_08]
        end
    end

    // Every power-on reset assertion, including a brown-out, returns the logic to standby.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin // [RULE_09]
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            drv_q <= 1'b0;
            rw_q <= 1'b0;
            hi_q <= 1'b0;
            addr_q <= '0;
            mack_q <= 1'b0;
            prot_q <= 1'b0;
            mask_q <= '0;
            page_q <= '0;
            cm_q <= CM_IDLE;
            ci_q <= '0;
            tmr_q <= '0;
            pend_q <= 1'b0;
            pu_cnt_q <= '0;
            pu_done_q <= 1'b0;
            ready_q <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            drv_q <= drv_d;
            rw_q <= rw_d;
            hi_q <= hi_d;
            addr_q <= addr_d;
            mack_q <= mack_d;
            prot_q <= prot_d;
            mask_q <= mask_d;
            page_q <= page_d;
            cm_q <= cm_d;
            ci_q <= ci_d;
            tmr_q <= tmr_d;
            pend_q <= pend_d;
            pu_cnt_q <= pu_cnt_d;
            pu_done_q <= pu_done_d;
            ready_q <= ready;
            sda_o <= 1'b0;
            sda_oe_n_o <= !drv_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        pb_q <= pb_d;
    end

    ise_fifo #(
        .W($bits(ise_wr_entry_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_data_i(fifo_in),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out),
        .out_ready_i(fifo_out_ready)
    );

    // Storage of 256 or 512 bytes organised as 16-byte pages. [RULE_01]
    ise_mem #(
        .W(DATA_W),
        .DEPTH(MEM_BYTES),
        .INIT(ERASED_BYTE)
    ) u_mem (
        .clk_i(mclk_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr[$clog2(MEM_BYTES)-1:0]),
        .wdata_i(pb_q[ci_q]),
        .raddr_i(addr_q[$clog2(MEM_BYTES)-1:0]),
        .rdata_o(mem_rdata)
    );

    assign ready_o = ready_q;
endmodule

// *** bench/ise_eeprom_properties.sv ***
`timescale 1ns/1ns
module ise_eeprom_properties #(
    parameter int PU_CYC = 50,
    parameter int WR_CYC = 200
) (
    input wire logic mclk_i, // Core clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic scl_i, // Serial clock pin.
    input wire logic sda_i, // Data wire level.
    input wire logic sda_o, // Data drive value.
    input wire logic sda_oe_n_o, // Low while pulling data low.
    input wire logic [2:0] chip_select_pins_i, // Address select pins.
    input wire logic wp_i, // Write protect pin.
    input wire logic ready_o // Device accepts commands.
);
    logic [31:0] low_cnt_q;
    logic [31:0] low_cnt_d;
    logic pu_seen_q;
    logic pu_seen_d;

    // Counts the cycles of the current not-ready stretch.
    always_comb begin
        low_cnt_d = ready_o ? 32'h0 : low_cnt_q + 32'h1;
        pu_seen_d = pu_seen_q | ready_o;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_q <= 32'h0;
            pu_seen_q <= 1'b0;
        end else begin
            low_cnt_q <= low_cnt_d;
            pu_seen_q <= pu_seen_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_drive_value_low: assert property (!sda_oe_n_o |-> sda_o == 1'b0)
        else $error("data line driven high");
    a_reset_leaves_idle: assert property ($rose(rst_n_i) |-> sda_oe_n_o && !ready_o)
        else $error("outputs not idle after reset");
    a_edge_after_fall: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 20))
        else $error("data drive changed outside filtered clock low");
    a_ack_stands: assert property ($fell(sda_oe_n_o) |=> !sda_oe_n_o [*8])
        else $error("driven low bit did not stand");
    a_release_stands: assert property ($rose(sda_oe_n_o) |=> sda_oe_n_o [*8])
        else $error("released bit did not stand");
    a_busy_releases_bus: assert property (!ready_o |-> sda_oe_n_o)
        else $error("bus driven while not ready");
    a_busy_bounded: assert property (low_cnt_q < WR_CYC + PU_CYC + 64)
        else $error("busy for too long");
    a_ready_minimum: assert property ($rose(ready_o) |-> low_cnt_q >= PU_CYC)
        else $error("ready returned too early");
    a_powerup_on_time: assert property (!pu_seen_q |-> low_cnt_q <= PU_CYC + 6)
        else $error("ready late after power up");

    c_ready_rise: cover property ($rose(ready_o));
    c_ready_fall: cover property ($fell(ready_o));
    c_bus_driven: cover property ($fell(sda_oe_n_o));
endmodule

bind ise_eeprom ise_eeprom_properties #(.PU_CYC(PU_CYC), .WR_CYC(WR_CYC)) u_props (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .chip_select_pins_i(chip_select_pins_i),
    .wp_i(wp_i),
    .ready_o(ready_o)
);

// *** bench/ise_i2c_master.sv ***
`timescale 1ns/1ns
module ise_i2c_master (
    input wire logic lclk_i, // Link timing clock, 125 ns.
    input wire logic sda_i, // Resolved data wire.
    output logic scl_o, // Serial clock, high while idle.
    output logic sda_oe_n_o // Low while pulling data low.
);
    logic glitch_en = 1'b0;

    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // Twelve link cycles low and eight high keep the bit at 2.5 us, the 400 kHz ceiling.
    task automatic bit_x(input logic b, output logic r);
        repeat (3) @(posedge lclk_i);
        sda_oe_n_o <= b;
        @(posedge lclk_i);
        if (glitch_en) begin
            scl_o <= 1'b1;
            #60;
            scl_o <= 1'b0;
        end
        repeat (8) @(posedge lclk_i);
        scl_o <= 1'b1;
        repeat (8) @(posedge lclk_i);
        r = sda_i;
        scl_o <= 1'b0;
    endtask

    task automatic start_c();
        repeat (3) @(posedge lclk_i);
        sda_oe_n_o <= 1'b1;
        repeat (8) @(posedge lclk_i);
        scl_o <= 1'b1;
        repeat (6) @(posedge lclk_i);
        sda_oe_n_o <= 1'b0;
        repeat (6) @(posedge lclk_i);
        scl_o <= 1'b0;
    endtask

    task automatic stop_c();
        repeat (3) @(posedge lclk_i);
        sda_oe_n_o <= 1'b0;
        repeat (8) @(posedge lclk_i);
        scl_o <= 1'b1;
        repeat (6) @(posedge lclk_i);
        sda_oe_n_o <= 1'b1;
        repeat (12) @(posedge lclk_i);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // The last byte of a read is refused so the device lets go of the line.
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, b[i]);
        end
        bit_x(last, r);
    endtask
endmodule

// *** bench/ise_eeprom_tb_top.sv ***
`timescale 1ns/1ns
module ise_eeprom_tb_top;
    import ise_pkg::*;

    localparam int PU = 50;
    localparam int WR = 8000;
    localparam int LIMIT = 99000;
    localparam logic [3:0] TYPE = 4'h6;
    localparam logic [1:0] SEL = 2'h2;

    logic mclk;
    logic lclk;
    logic rst_n;
    logic scl;
    logic sda_o;
    logic sda_oe_n;
    logic m_oe_n;
    logic sda_w;
    logic [2:0] cs_pins;
    logic wp;
    logic ready;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & m_oe_n;

    ise_eeprom #(.MEM_BYTES(MEM_BYTES_LARGE), .WR_CYC(WR), .PU_CYC(PU), .TYPE_CODE(TYPE), .FIFO_DEPTH(2)) dut (
        .mclk_i(mclk),
        .rst_n_i(rst_n),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n),
        .chip_select_pins_i(cs_pins),
        .wp_i(wp),
        .ready_o(ready)
    );

    ise_i2c_master master (
        .lclk_i(lclk),
        .sda_i(sda_w),
        .scl_o(scl),
        .sda_oe_n_o(m_oe_n)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        lclk = 1'b0;
        #37;
        forever begin
            #62 lclk = ~lclk;
            #63 lclk = ~lclk;
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic chk_bit(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    function automatic logic [7:0] dev_b(input logic [1:0] sel, input logic a8, input logic rd);
        return {TYPE, sel, a8, rd};
    endfunction

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < WR + PU + 100) begin
            @(posedge mclk);
            n++;
        end
        chk_bit(1'b1, ready);
    endtask

    // The master waits for ready before addressing the device.
    task automatic t_powerup();
        chk_bit(1'b0, ready);
        wait_ready();
        $display("test powerup done");
    endtask

    task automatic t_page_write();
        logic a;
        master.glitch_en = 1'b1;
        master.start_c();
        master.send(dev_b(SEL, 1'b1, 1'b0), a);
        chk_bit(1'b1, a);
        master.send(8'h0F, a);
        chk_bit(1'b1, a);
        master.send(8'hA5, a);
        chk_bit(1'b1, a);
        master.send(8'h3C, a);
        chk_bit(1'b1, a);
        master.stop_c();
        master.glitch_en = 1'b0;
        chk_bit(1'b0, ready);
        master.start_c();
        master.send(dev_b(SEL, 1'b0, 1'b0), a);
        chk_bit(1'b0, a);
        master.stop_c();
        wait_ready();
        $display("test page_write done");
    endtask

    task automatic t_sel_read();
        logic a;
        logic [7:0] b;
        master.start_c();
        master.send(dev_b(SEL, 1'b1, 1'b0), a);
        master.send(8'h00, a);
        master.start_c();
        master.send(dev_b(SEL, 1'b1, 1'b1), a);
        chk_bit(1'b1, a);
        master.recv(1'b0, b);
        chk_byte(8'h3C, b);
        master.recv(1'b1, b);
        chk_byte(ERASED_BYTE, b);
        master.stop_c();
        $display("test sel_read done");
    endtask

    task automatic t_protect();
        logic a;
        @(posedge mclk);
        wp <= 1'b1;
        master.start_c();
        master.send(dev_b(SEL, 1'b1, 1'b0), a);
        chk_bit(1'b1, a);
        master.send(8'h20, a);
        master.send(8'h77, a);
        chk_bit(1'b0, a);
        master.stop_c();
        chk_bit(1'b1, ready);
        @(posedge mclk);
        wp <= 1'b0;
        $display("test protect done");
    endtask

    task automatic t_bad_select();
        logic a;
        master.start_c();
        master.send(dev_b(~SEL, 1'b0, 1'b0), a);
        chk_bit(1'b0, a);
        master.stop_c();
        $display("test bad_select done");
    endtask

    task automatic t_brownout();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_bit(1'b0, ready);
        rst_n <= 1'b1;
        wait_ready();
        $display("test brownout done");
    endtask

    initial begin
        rst_n = 1'b0;
        cs_pins = 3'h5;
        wp = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_powerup();
        t_page_write();
        t_sel_read();
        t_protect();
        t_bad_select();
        t_brownout();
        finish_test();
    end
endmodule
